// ===== inc/hdr_defines.vh
// Constants for the record header builder: layout, status bit positions, register offsets
`ifndef HDR_DEFINES_VH
`define HDR_DEFINES_VH

// Header geometry
`define HDR_BYTES        6'd40
`define HDR_WORDS        4'd10
`define HDR_LAST_WORD    4'd9

// Status byte bit positions
`define ST_RANGE_BIT     7
`define ST_FILL_HI       6
`define ST_FILL_LO       4
`define ST_LOST_END      3
`define ST_LOST_MID      2
`define ST_LOST_START    1
`define ST_LOST_RECORD   0

// Fill level quantiser: eight steps of 12.5 percent
`define FILL_STEPS       4'd8

// Data format codes
`define FMT_16BIT        8'h00
`define FMT_32BIT        8'h01

// Register offsets on the plain register port
`define REG_USER_ID      4'h0
`define REG_SERIAL       4'h1
`define REG_CHANNEL      4'h2
`define REG_FORMAT       4'h3
`define REG_GP_WORD      4'h4
`define REG_RECORD_NUM   4'h5
`define REG_TS_RESETS    4'h6
`define REG_LAST_STATUS  4'h7
`define REG_HDR_COUNT    4'h8

// Reset values
`define USER_ID_RST      8'h00
`define SERIAL_RST       32'h00000000
`define CHANNEL_RST      8'h00
`define FORMAT_RST       8'h00
`define GP_WORD_RST      16'h0000

`endif

// ===== hdl/peak_fill_tracker.v
// Tracks the highest FIFO fill level seen during a record and quantises it
`timescale 1ns/100ps
`include "hdr_defines.vh"

module peak_fill_tracker #(
	parameter FILL_W = 16                        // Width of the fill level count
) (
	input  wire              clk_in,             // System clock
	input  wire              rstn_in,            // Asynchronous reset, active low
	input  wire              start_in,           // Record starts, restarts the peak
	input  wire [FILL_W-1:0] fill_in,            // Current fill level
	input  wire [FILL_W-1:0] depth_in,           // FIFO capacity
	output wire [2:0]        code_out            // Peak level in eighths
);

	reg  [FILL_W-1:0] peak_q;                     // Highest level in this record
	wire [FILL_W-1:0] peak_now;                   // Peak including this cycle
	wire [FILL_W+2:0] scaled;                     // Peak times eight
	reg  [2:0]        code;                       // Quantised code

	// Include the present sample so a peak in the last cycle is not missed
	assign peak_now = (fill_in > peak_q) ? fill_in : peak_q;
	assign scaled   = {peak_now, 3'b000};

	// Keep the running maximum; a new record starts from the current level
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			peak_q <= {FILL_W{1'b0}};
		end else if (start_in) begin
			peak_q <= fill_in;
		end else begin
			peak_q <= peak_now;
		end
	end

	// Largest k with peak*8 > k*depth, saturating at 7 (above 87.5 percent)
	always @* begin : quant
		integer k;
		code = 3'b000;
		for (k = 1; k < `FILL_STEPS; k = k + 1) begin
			if (scaled > depth_in * k) begin
				code = k[2:0];
			end
		end
	end

	assign code_out = code;

endmodule

// ===== hdl/header_word_rom.v
// Registered 10-word view of the 40-byte header image
`timescale 1ns/100ps
`include "hdr_defines.vh"

module header_word_rom (
	input  wire         clk_in,                  // System clock
	input  wire         rstn_in,                 // Asynchronous reset, active low
	input  wire [319:0] image_in,                // Header image, byte 0 in bits 7:0
	input  wire [3:0]   index_in,                // Word to read
	output reg  [31:0]  word_out                 // Registered word
);

	// Word select registered so the output comes straight from a flip-flop
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			word_out <= 32'h00000000;
		end else if (index_in <= `HDR_LAST_WORD) begin
			word_out <= image_in[index_in*32 +: 32];
		end else begin
			word_out <= 32'h00000000;                 // Out of range words read zero
		end
	end

endmodule

// ===== hdl/record_header_builder.v
// Record header builder: collects record metadata and streams a 40-byte header
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "hdr_defines.vh"

module record_header_builder #(
	parameter FILL_W = 16                            // Width of the FIFO fill count
) (
	input  wire              clk_in,                 // Acquisition clock, 200 MHz
	input  wire              rstn_in,                // Power-up reset, asynchronous, active low
	// Register port
	input  wire [3:0]        reg_addr_in,            // Register word index
	input  wire [31:0]       reg_wdata_in,           // Write data
	input  wire              reg_wr_in,              // Write strobe
	input  wire              reg_rd_in,              // Read strobe
	output reg  [31:0]       reg_rdata_out,          // Read data, one cycle after the strobe
	// Acquisition engine events
	input  wire              rec_start_in,           // Pulse: a record begins capture
	input  wire              rec_end_in,             // Pulse: record done, build header
	input  wire              range_in,               // Level: sample over/under range this cycle
	input  wire              lost_record_in,         // Pulse: record lost, header goes out alone
	input  wire              lost_start_in,          // Pulse: start of record dropped
	input  wire              lost_mid_in,            // Pulse: body section dropped
	input  wire              lost_end_in,            // Pulse: end of record dropped
	input  wire [FILL_W-1:0] fifo_fill_in,           // Current FIFO fill
	input  wire [FILL_W-1:0] fifo_depth_in,          // FIFO capacity
	input  wire [31:0]       sample_period_in,       // Signed sample period, 25 ps units
	input  wire [63:0]       trigger_time_in,        // Trigger time, 25 ps units
	input  wire [63:0]       record_start_in,        // Signed trigger-to-start offset, 25 ps units
	input  wire [31:0]       record_length_in,       // Samples in the record
	input  wire              ts_reset_in,            // Pulse: timestamp counter was reset
	// Header stream
	output reg  [31:0]       hdr_data_out,           // Header word, bytes little-endian
	output reg               hdr_valid_out,          // Header word valid
	output reg               hdr_last_out,           // Last of the ten words
	input  wire              hdr_ready_in,           // Downstream accepts the word
	output wire              busy_out                // Header still being sent
);

	// Sender states; a header leaves word by word through load and send
	localparam ST_IDLE = 2'b00;                      // Waiting for record end
	localparam ST_LOAD = 2'b01;                      // Word fetch in progress
	localparam ST_SEND = 2'b10;                      // Word presented downstream

	// Software settings
	reg  [7:0]   user_id_q;                          // Unit tag
	reg  [31:0]  serial_q;                           // Numeric serial number
	reg  [7:0]   channel_q;                          // Source channel code
	reg  [7:0]   format_q;                           // Sample format code
	reg  [15:0]  gp_word_q;                          // General purpose word

	// Record bookkeeping
	reg  [31:0]  record_num_q;                       // Records since power-up
	reg  [15:0]  ts_resets_q;                        // Timestamp reset count
	reg          range_q;                            // Sticky range flag for this record
	reg  [3:0]   lost_q;                             // Sticky lost-data flags
	reg  [31:0]  hdr_count_q;                        // Headers fully sent
	reg  [7:0]   last_status_q;                      // Status of the latest header

	// Frozen header image and sender
	reg  [319:0] image_q;                            // Latched 40-byte header
	reg  [1:0]   state_q;                            // Sender state
	reg  [3:0]   word_idx_q;                         // Next word to fetch
	wire [31:0]  rom_word;                           // Registered image word

	// Combinational helpers around the status and format bytes
	wire [2:0]   fill_code;                          // Quantised peak fill
	wire [7:0]   status_byte;                        // Assembled status byte
	wire [3:0]   lost_now;                           // Lost flags incl. this cycle
	wire         range_now;                          // Range flag incl. this cycle
	wire [7:0]   fmt_legal;                          // Format limited to known codes

	// Peak fill over the record, quantised to eighths of the FIFO.
	// Restarted by record start, so each record reports its own peak.
	peak_fill_tracker #(
		.FILL_W   (FILL_W)
	) u_fill (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.start_in (rec_start_in),
		.fill_in  (fifo_fill_in),
		.depth_in (fifo_depth_in),
		.code_out (fill_code)
	);

	// Word register between the frozen image and the stream output.
	// An index past the last word reads zero, harmless between headers.
	header_word_rom u_rom (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.image_in (image_q),
		.index_in (word_idx_q),
		.word_out (rom_word)
	);

	// Events in the closing cycle still count, so the flags never miss them
	// Without this, a loss in the very cycle of record end would be cleared and reach no header
	assign range_now = range_q | range_in;
	assign lost_now  = lost_q | {lost_end_in, lost_mid_in, lost_start_in, lost_record_in};

	// Status byte: range, peak fill, lost flags in their documented bits
	// Bit order from the top: range, fill code, end, middle, start, whole record
	assign status_byte = {range_now,
	                      fill_code,
	                      lost_now[`ST_LOST_END - `ST_LOST_RECORD],
	                      lost_now[`ST_LOST_MID - `ST_LOST_RECORD],
	                      lost_now[`ST_LOST_START - `ST_LOST_RECORD],
	                      lost_now[`ST_LOST_RECORD]};

	// Only the two defined codes are sent; anything else falls back to 16-bit
	// The raw code stays in its register so software reads back what it wrote
	assign fmt_legal = (format_q == `FMT_32BIT) ? `FMT_32BIT : `FMT_16BIT;

	// Register writes; settings hold until software changes them
	// The bus master never raises both strobes, so writes and reads stay apart
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Settings start at zero; software programs them before arming
			user_id_q <= `USER_ID_RST;
			serial_q  <= `SERIAL_RST;
			channel_q <= `CHANNEL_RST;
			format_q  <= `FORMAT_RST;
			gp_word_q <= `GP_WORD_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`REG_USER_ID: begin
					user_id_q <= reg_wdata_in[7:0];
				end
				`REG_SERIAL: begin
					serial_q <= reg_wdata_in;
				end
				`REG_CHANNEL: begin
					channel_q <= reg_wdata_in[7:0];
				end
				`REG_FORMAT: begin
					// Kept raw; only a legal code reaches the header
					format_q <= reg_wdata_in[7:0];
				end
				`REG_GP_WORD: begin
					// Copied unchanged into bytes 36-37 of every header
					gp_word_q <= reg_wdata_in[15:0];
				end
				`REG_RECORD_NUM, `REG_TS_RESETS, `REG_LAST_STATUS, `REG_HDR_COUNT: begin
					// Read-only: software cannot disturb the counters
				end
				default: begin
					// Unmapped address: write ignored
				end
			endcase
		end
	end

	// Register reads; data stands in the cycle after the strobe only
	// Reads have no side effects, so software may poll any register freely
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`REG_USER_ID: begin
					reg_rdata_out <= {24'h000000, user_id_q};
				end
				`REG_SERIAL: begin
					reg_rdata_out <= serial_q;
				end
				`REG_CHANNEL: begin
					reg_rdata_out <= {24'h000000, channel_q};
				end
				`REG_FORMAT: begin
					reg_rdata_out <= {24'h000000, format_q};
				end
				`REG_GP_WORD: begin
					reg_rdata_out <= {16'h0000, gp_word_q};
				end
				`REG_RECORD_NUM: begin
					reg_rdata_out <= record_num_q;
				end
				`REG_TS_RESETS: begin
					reg_rdata_out <= {16'h0000, ts_resets_q};
				end
				`REG_LAST_STATUS: begin
					reg_rdata_out <= {24'h000000, last_status_q};
				end
				`REG_HDR_COUNT: begin
					reg_rdata_out <= hdr_count_q;
				end
				default: begin
					reg_rdata_out <= 32'h00000000;      // Unmapped reads zero
				end
			endcase
		end else begin
			// No strobe: data returns to zero so a stale word is never taken twice
			reg_rdata_out <= 32'h00000000;
		end
	end

	// Record counter; only power-up clears it, re-arming leaves it running.
	// It moves at record start, so a header knows its number while capture runs.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			record_num_q <= 32'h00000000;
		end else if (rec_start_in) begin
			record_num_q <= record_num_q + 32'h00000001; // Natural wrap to zero
		end
	end

	// Timestamp reset count; sixteen bits, wraps without a flag
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ts_resets_q <= 16'h0000;
		end else if (ts_reset_in) begin
			ts_resets_q <= ts_resets_q + 16'h0001;
		end
	end

	// Sticky per-record flags: cleared at record start, but an event in that
	// same cycle still sets them, so a loss at the boundary is not dropped.
	// A record end that the sender refuses still clears them: space records.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			range_q <= 1'b0;
			lost_q  <= 4'h0;
		end else if (rec_start_in) begin
			// Restart, keeping events of this very cycle (set wins)
			range_q <= range_in;
			lost_q  <= {lost_end_in, lost_mid_in, lost_start_in, lost_record_in};
		end else if (rec_end_in) begin
			// Flags went into the image at this edge unless busy; start afresh
			range_q <= 1'b0;
			lost_q  <= 4'h0;
		end else begin
			// Accumulate over the record body
			range_q <= range_now;
			lost_q  <= lost_now;
		end
	end

	// Freeze the whole header at record end: fields in order, little-endian.
	// Record number in the header is the counter value before this record's start.
	// A record end while busy leaves the previous image untouched.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Power-up image is all zero; the stream never sends it
			image_q       <= 320'h0;
			last_status_q <= 8'h00;
		end else if (rec_end_in && state_q == ST_IDLE) begin
			image_q <= {ts_resets_q,                    // Bytes 38-39
			            gp_word_q,                      // Bytes 36-37
			            record_length_in,               // Bytes 32-35
			            record_start_in,                // Bytes 24-31
			            trigger_time_in,                // Bytes 16-23
			            sample_period_in,               // Bytes 12-15
			            record_num_q - 32'h00000001,    // Bytes 8-11
			            serial_q,                       // Bytes 4-7
			            fmt_legal,                      // Byte 3
			            channel_q,                      // Byte 2
			            user_id_q,                      // Byte 1
			            status_byte};                   // Byte 0
			// Status also kept for software to read
			last_status_q <= status_byte;
		end
	end

	// Sender: fetch a word, present it, wait for ready, ten words per header.
	// A record end while busy is ignored; the engine must space records.
	// Timing: record end at edge 0, first valid stands from edge 3; after each
	// accepted word valid stays low two cycles while the next word is fetched.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Stream outputs start low so no false word follows reset
			state_q       <= ST_IDLE;
			word_idx_q    <= 4'h0;
			hdr_data_out  <= 32'h00000000;
			hdr_valid_out <= 1'b0;
			hdr_last_out  <= 1'b0;
			hdr_count_q   <= 32'h00000000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// The image freezes at this same edge, so fetching starts at once
					if (rec_end_in) begin
						word_idx_q <= 4'h0;
						state_q    <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					// Image latched or word accepted, wait one cycle for the word register
					// Valid is already low here; the assignment keeps the stream quiet
					word_idx_q <= word_idx_q + 4'h1;
					state_q    <= ST_SEND;
					hdr_valid_out <= 1'b0;
				end
				ST_SEND: begin
					if (!hdr_valid_out) begin
						// Present the word fetched in the load cycle
						hdr_data_out  <= rom_word;
						hdr_valid_out <= 1'b1;
						hdr_last_out  <= (word_idx_q == `HDR_WORDS);
					end else if (hdr_ready_in) begin
						// Accepted: finish the header or fetch the next word
						hdr_valid_out <= 1'b0;
						hdr_last_out  <= 1'b0;
						if (hdr_last_out) begin
							// Whole header delivered: count it for software
							hdr_count_q <= hdr_count_q + 32'h00000001;
							state_q     <= ST_IDLE;
						end else begin
							// More words to go
							state_q <= ST_LOAD;
						end
					end
				end
				default: begin
					// Unused code: back to idle rather than hang
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Busy covers load and send, so the engine can hold back its next record end
	assign busy_out = (state_q != ST_IDLE);

endmodule

// ===== sim/record_header_builder_sva.sv
// Concurrent checks on the header stream and the register read port
`timescale 1ns/100ps
module record_header_builder_sva (
	input wire logic        clk_in,         // Clock
	input wire logic        rstn_in,        // Reset, active low
	input wire logic        reg_rd_in,      // Read strobe
	input wire logic [31:0] reg_rdata_out,  // Read data
	input wire logic        rec_end_in,     // Record done
	input wire logic [31:0] hdr_data_out,   // Header word
	input wire logic        hdr_valid_out,  // Word valid
	input wire logic        hdr_last_out,   // Last word
	input wire logic        hdr_ready_in,   // Sink accepts
	input wire logic        busy_out        // Header in flight
);
	logic [3:0] cnt_q;  // Words accepted so far in this header
	// Count accepted words; the last one restarts the count
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= 4'h0;
		end else if (hdr_valid_out && hdr_ready_in) begin
			cnt_q <= hdr_last_out ? 4'h0 : cnt_q + 4'h1;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	property p_first; rec_end_in && !busy_out |-> !hdr_valid_out ##3 hdr_valid_out; endproperty
	a_first: assert property (p_first) else $error("first word not three cycles after record end");
	property p_hold; hdr_valid_out && !hdr_ready_in |=> hdr_valid_out && $stable(hdr_data_out) && $stable(hdr_last_out); endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");
	property p_gap; hdr_valid_out && hdr_ready_in && !hdr_last_out |=> !hdr_valid_out [*2] ##1 hdr_valid_out; endproperty
	a_gap: assert property (p_gap) else $error("word spacing wrong");
	property p_ten; hdr_valid_out && hdr_last_out |-> cnt_q == 4'h9; endproperty
	a_ten: assert property (p_ten) else $error("last flag not on tenth word");
	property p_nine; hdr_valid_out && cnt_q == 4'h9 |-> hdr_last_out; endproperty
	a_nine: assert property (p_nine) else $error("tenth word lacks last flag");
	property p_done; hdr_valid_out && hdr_ready_in && hdr_last_out |=> !busy_out && !hdr_valid_out; endproperty
	a_done: assert property (p_done) else $error("busy after final word");
	property p_busy; hdr_valid_out |-> busy_out; endproperty
	a_busy: assert property (p_busy) else $error("valid while not busy");
	property p_fmt; hdr_valid_out && cnt_q == 4'h0 |-> hdr_data_out[31:24] <= 8'h01; endproperty
	a_fmt: assert property (p_fmt) else $error("format byte out of range");
	property p_rd; reg_rdata_out != 32'h0 |-> $past(reg_rd_in); endproperty
	a_rd: assert property (p_rd) else $error("read data without strobe");
endmodule
bind record_header_builder record_header_builder_sva chk (.clk_in(clk_in), .rstn_in(rstn_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rec_end_in(rec_end_in), .hdr_data_out(hdr_data_out),
	.hdr_valid_out(hdr_valid_out), .hdr_last_out(hdr_last_out), .hdr_ready_in(hdr_ready_in), .busy_out(busy_out));

// ===== sim/hdr_sink.sv
// Sink model for the header stream: stalls on command and keeps the last header
`timescale 1ns/100ps
module hdr_sink (
	input  wire logic        clk_in,     // Clock
	input  wire logic        rstn_in,    // Reset, active low
	input  wire logic [31:0] data_in,    // Header word
	input  wire logic        valid_in,   // Word valid
	input  wire logic        last_in,    // Last word
	input  wire logic        stall_in,   // Hold off acceptance
	output logic             ready_out,  // Accepts the word
	output logic [319:0]     image_out,  // Last complete header, byte 0 low
	output logic [7:0]       got_out     // Headers received
);
	logic [319:0] img_q;  // Header being gathered
	logic [3:0]   n_q;    // Next word slot
	// Plain level; a slow host is modelled by holding stall
	assign ready_out = !stall_in;
	// Gather words in arrival order so byte order is checked as a whole
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			img_q <= '0;
			n_q <= 4'h0;
			image_out <= '0;
			got_out <= 8'h00;
		end else if (valid_in && ready_out) begin
			img_q[n_q*32 +: 32] <= data_in;
			n_q <= last_in ? 4'h0 : n_q + 4'h1;
			if (last_in) begin
				image_out <= {data_in, img_q[287:0]};
				got_out <= got_out + 8'h01;
			end
		end
	end
endmodule

// ===== sim/record_header_builder_test.sv
// Self-checking bench for the record header builder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module record_header_builder_test;
	logic clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;  // Clock, reset, strobes
	logic rec_start_in = 1'b0, rec_end_in = 1'b0, range_in = 1'b0, ts_reset_in = 1'b0, stall = 1'b0;
	logic [3:0]   reg_addr_in = 4'h0, lost = 4'h0;     // Address; loss pulses in status bit order
	logic [31:0]  reg_wdata_in = 32'h0, per = 32'h0, len = 32'h0;
	logic [63:0]  tt = 64'h0, rs = 64'h0;               // Trigger time and start offset
	logic [15:0]  fill = 16'h0010, gp = 16'h0, tsr = 16'h0;
	logic [31:0]  reg_rdata_out, hdr_data_out, ser = 32'h0, starts = 32'h0;
	logic         hdr_valid_out, hdr_last_out, hdr_ready_in, busy_out;
	logic [319:0] image;                                // Header seen by the sink
	logic [7:0]   got, uid = 8'h0, ch = 8'h0, fmt = 8'h0;
	int           fail_count = 0, total_checks = 0, cyc = 0;
	record_header_builder #(.FILL_W(16)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.rec_start_in(rec_start_in), .rec_end_in(rec_end_in), .range_in(range_in), .lost_record_in(lost[0]),
		.lost_start_in(lost[1]), .lost_mid_in(lost[2]), .lost_end_in(lost[3]), .fifo_fill_in(fill),
		.fifo_depth_in(16'h0100), .sample_period_in(per), .trigger_time_in(tt), .record_start_in(rs),
		.record_length_in(len), .ts_reset_in(ts_reset_in), .hdr_data_out(hdr_data_out),
		.hdr_valid_out(hdr_valid_out), .hdr_last_out(hdr_last_out), .hdr_ready_in(hdr_ready_in), .busy_out(busy_out));
	hdr_sink sink (.clk_in(clk_in), .rstn_in(rstn_in), .data_in(hdr_data_out), .valid_in(hdr_valid_out),
		.last_in(hdr_last_out), .stall_in(stall), .ready_out(hdr_ready_in), .image_out(image), .got_out(got));
	// 200 MHz clock
	initial forever #2.5 clk_in = ~clk_in;
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One-cycle write; an edge passes before the next strobe
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// Data is looked at only in the cycle after the strobe
	task rd(input [3:0] a, input [31:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 `CHK("rdata", e, reg_rdata_out)
	endtask
	// Begin a record with fields unique to it
	task start_rec();
		@(posedge clk_in);
		starts = starts + 32'h1;
		rec_start_in <= 1'b1;
		per <= 32'hffffff00 | starts;
		tt <= {32'h89abcdef, starts};
		rs <= 64'hfffffffffffff000 | starts;
		len <= 32'h00000100 + starts;
		@(posedge clk_in);
		rec_start_in <= 1'b0;
	endtask
	// End a record, release a stall set by the caller after hold cycles, compare the whole header
	task finish_rec(input [7:0] st, input int hold);
		int i;
		logic [7:0] n;
		@(posedge clk_in);
		rec_end_in <= 1'b1;
		@(posedge clk_in);
		rec_end_in <= 1'b0;
		n = got;
		repeat (hold) @(posedge clk_in);
		stall <= 1'b0;
		for (i = 0; i < 200 && got == n; i++) @(posedge clk_in);
		#1 `CHK("header", {tsr, gp, len, rs, tt, per, starts - 32'h1, ser, fmt, ch, uid, st}, image)
		rd(4'h7, {24'h0, st});
	endtask
	task t_regs();
		wr(4'h0, 32'hffffff5a);
		uid = 8'h5a;
		wr(4'h1, 32'h00012345);
		ser = 32'h00012345;
		wr(4'h2, 32'h00000021);
		ch = 8'h21;
		wr(4'h3, 32'h00000007);
		wr(4'h4, 32'h0000beef);
		gp = 16'hbeef;
		wr(4'h5, 32'h12345678);
		rd(4'h0, 32'h0000005a);
		rd(4'h1, ser);
		rd(4'h2, 32'h00000021);
		rd(4'h3, 32'h00000007);
		rd(4'h4, 32'h0000beef);
		rd(4'h5, 32'h0);
		rd(4'hf, 32'h0);
		$display("Test regs done");
	endtask
	task t_plain();
		start_rec();
		finish_rec(8'h00, 0);
		rd(4'h8, 32'h00000001);
		$display("Test plain done");
	endtask
	task t_flags();
		start_rec();
		@(posedge clk_in);
		fill <= 16'h00f0;
		range_in <= 1'b1;
		lost <= 4'b0100;
		@(posedge clk_in);
		fill <= 16'h0010;
		range_in <= 1'b0;
		lost <= 4'b1000;
		@(posedge clk_in);
		lost <= 4'b0000;
		stall <= 1'b1;
		finish_rec(8'hfc, 20);
		$display("Test flags done");
	endtask
	task t_lost();
		logic [7:0] n;
		repeat (2) begin
			@(posedge clk_in);
			ts_reset_in <= 1'b1;
			@(posedge clk_in);
			ts_reset_in <= 1'b0;
		end
		tsr = tsr + 16'h2;
		wr(4'h3, 32'h00000001);
		fmt = 8'h01;
		start_rec();
		@(posedge clk_in);
		fill <= 16'h0020;
		lost <= 4'b0011;
		@(posedge clk_in);
		fill <= 16'h0010;
		lost <= 4'b0000;
		finish_rec(8'h03, 0);
		rd(4'h6, {16'h0, tsr});
		n = got;
		start_rec();
		@(posedge clk_in);
		rec_end_in <= 1'b1;
		@(posedge clk_in);
		rec_end_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		rec_end_in <= 1'b1;
		@(posedge clk_in);
		rec_end_in <= 1'b0;
		repeat (100) @(posedge clk_in);
		`CHK("headers", n + 8'h01, got)
		$display("Test lost done");
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_regs();
		t_plain();
		t_flags();
		t_lost();
		end_of_test();
	end
endmodule
